// ---- hdl/dsf_status_flags.sv ----
`timescale 1ns/100ps
`include "dsf_params.svh"

// How it works
// - A new command arriving while the current one is still busy sets the overrun flag at bit 4.
// - With handshake pulses on, the host pulling the debug pin low during a pending pulse sets overrun.
// - Overrun blocks internal debug accesses until a SYNC, and only a SYNC clears it.
// - An access that finds no free bus cycle within 512 core cycles sets no-response at bit 3.
// - With handshake off or cycle stealing on, an unfinished read at data retrieval or an unfinished write at the next command sets no-response.
// - In stop mode with the stop-clock keep bit clear, memory or PC sampling accesses set no-response.
// - No-response set by an access cause aborts an abortable access, but not while the external wait is asserted.
// - An enter-debug command in wait mode sets no-response without abort and completes after wait ends.
// - Every CPU register command in wait mode sets no-response again.
// - Any command arriving while the CPU has not yet returned from wait sets no-response.
// - A single step issued with the controller enabled as the device enters wait sets no-response.
// - While no-response is set, every data byte returned is 0xEE.
// - No-response and read-invalid clear only by writing one to their bit; zero leaves them.
// - An ECC error on a debug read sets read-invalid at bit 2.
// - A read that raises read-invalid with no-response clear still returns the data actually read.
module dsf_status_flags #(
  parameter int NO_RESPONSE_FLAG_CYCLES = `DSF_NO_RESPONSE_FLAG_CYCLES
) (
  // Clock, reset and clock enable
  input  wire logic                sys_clk,
  input  wire logic                reset_n,
  input  wire logic                clkEn,
  // Debug pin level, asynchronous to sys_clk
  input  wire logic                debugPin,
  // Decoder, mode and bus inputs
  input  wire dsf_pkg::dsf_cmd_s   cmdIn,
  input  wire dsf_pkg::dsf_mode_s  modeIn,
  input  wire dsf_pkg::dsf_access_s accessIn,
  // Host write of the low status byte
  input  wire logic                statusWrite,
  input  wire logic [7:0]          statusWrData,
  // Results
  output logic [7:0]               debugStatusLow,
  output logic                     accessSuppress,
  output logic                     abortAccess,
  output logic                     debugEnter,
  output logic [7:0]               readDataOut,
  output logic                     readDataValid
);
  import dsf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic       pinSync1;
  logic       pinSync2;
  logic       pinPrev;
  logic       pinFall;
  logic       timeoutHit;
  logic       ovrSet;
  logic       nrAccessSet;
  logic       nrSet;
  logic       riSet;
  logic       nrClear;
  logic       riClear;
  logic [7:0] status_next;
  logic       enterPend_reg;
  logic       enterPend_next;
  logic       debugEnter_next;
  logic       abortAccess_next;
  logic [7:0] readDataOut_next;
  dsf_abort_e abort_reg;
  dsf_abort_e abort_next;

  function automatic logic bitAt(input logic [7:0] val, input logic [2:0] pos);
    bitAt = val[pos];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // The pin is synchronised before the edge detector sees it.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinSync1 <= 1'b1;
      pinSync2 <= 1'b1;
      pinPrev  <= 1'b1;
    end else if (clkEn) begin
      pinSync1 <= debugPin;
      pinSync2 <= pinSync1;
      pinPrev  <= pinSync2;
    end
  end

  assign pinFall = pinPrev & ~pinSync2;

  dsf_timeout #(
    .LIMIT (NO_RESPONSE_FLAG_CYCLES),
    .WIDTH (`DSF_TIMER_WIDTH)
  ) u_timeout (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clkEn   (clkEn),
    .waiting (accessIn.accessReq & ~accessIn.freeCycle & ~accessSuppress),
    .expired (timeoutHit)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    ovrSet = (cmdIn.cmdStart & cmdIn.cmdBusy)
           | (modeIn.ackEnable & modeIn.ackPending & pinFall);
    nrAccessSet = timeoutHit
      | ((~modeIn.ackEnable | modeIn.cycleBitA) & accessIn.accessReq
         & ((~accessIn.isWrite & cmdIn.dataRetrieveStart)
            | (accessIn.isWrite & cmdIn.cmdStart)))
      | (modeIn.stopMode & ~modeIn.stopClockKeep & cmdIn.memOrPcCmd);
    nrSet = nrAccessSet
      | (modeIn.waitMode & cmdIn.enterDebugCmd)
      | (modeIn.waitMode & cmdIn.cpuRegCmd)
      | (modeIn.waitReturnPending & cmdIn.cmdStart)
      | (modeIn.enteringWait & modeIn.bdcEnabled & cmdIn.singleStepCmd);
    riSet   = accessIn.readValid & accessIn.eccError;
    nrClear = statusWrite & bitAt(statusWrData, `DSF_NO_RESPONSE_FLAG_BIT);
    riClear = statusWrite & bitAt(statusWrData, `DSF_READ_INVALID_FLAG_BIT);

    // Flags other than these three are held elsewhere and read as zero here.
    status_next = `DSF_STATUS_RESET;
    status_next[`DSF_OVERRUN_BIT] = ovrSet
      | (bitAt(debugStatusLow, `DSF_OVERRUN_BIT) & ~cmdIn.syncReq);
    status_next[`DSF_NO_RESPONSE_FLAG_BIT] = nrSet
      | (bitAt(debugStatusLow, `DSF_NO_RESPONSE_FLAG_BIT) & ~nrClear);
    status_next[`DSF_READ_INVALID_FLAG_BIT] = riSet
      | (bitAt(debugStatusLow, `DSF_READ_INVALID_FLAG_BIT) & ~riClear);

    // Data returned follows the flag value of the same access.
    readDataOut_next = bitAt(status_next, `DSF_NO_RESPONSE_FLAG_BIT) ? `DSF_SUBST_BYTE
                                                         : accessIn.readData;
  end

  ////////////////////////////////////////////////////////////////////////////
  // An abort held off by the external wait is kept pending, since the bus
  // cannot drop an external cycle mid-flight.
  always_comb begin
    abort_next       = abort_reg;
    abortAccess_next = 1'b0;
    unique case (abort_reg)
      DSF_AB_IDLE: begin
        if (nrAccessSet && accessIn.abortable) begin
          if (accessIn.extWait) begin
            abort_next = DSF_AB_HOLD;
          end else begin
            abortAccess_next = 1'b1;
          end
        end
      end
      DSF_AB_HOLD: begin
        if (!accessIn.extWait) begin
          abortAccess_next = 1'b1;
          abort_next       = DSF_AB_IDLE;
        end
      end
    endcase
  end

  // Enter-debug in wait mode is remembered and released when wait ends.
  always_comb begin
    enterPend_next  = enterPend_reg;
    debugEnter_next = 1'b0;
    if (cmdIn.enterDebugCmd && modeIn.waitMode) begin
      enterPend_next = 1'b1;
    end else if (enterPend_reg && !modeIn.waitMode) begin
      enterPend_next  = 1'b0;
      debugEnter_next = 1'b1;
    end else if (cmdIn.enterDebugCmd) begin
      debugEnter_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      debugStatusLow <= `DSF_STATUS_RESET;
      accessSuppress <= 1'b0;
      abort_reg      <= DSF_AB_IDLE;
      abortAccess    <= 1'b0;
      enterPend_reg  <= 1'b0;
      debugEnter     <= 1'b0;
      readDataOut    <= 8'h00;
      readDataValid  <= 1'b0;
    end else if (clkEn) begin
      debugStatusLow <= status_next;
      accessSuppress <= status_next[`DSF_OVERRUN_BIT];
      abort_reg      <= abort_next;
      abortAccess    <= abortAccess_next;
      enterPend_reg  <= enterPend_next;
      debugEnter     <= debugEnter_next;
      readDataOut    <= readDataOut_next;
      readDataValid  <= accessIn.readValid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_ovr_set;
    clkEn && cmdIn.cmdStart && cmdIn.cmdBusy
      |=> debugStatusLow[`DSF_OVERRUN_BIT] && accessSuppress;
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun not set");

  property p_ovr_sticky;
    clkEn && debugStatusLow[`DSF_OVERRUN_BIT] && !cmdIn.syncReq
      |=> debugStatusLow[`DSF_OVERRUN_BIT];
  endproperty
  a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun lost");

  property p_ovr_sync;
    clkEn && cmdIn.syncReq && !ovrSet
      |=> !debugStatusLow[`DSF_OVERRUN_BIT] && !accessSuppress;
  endproperty
  a_ovr_sync: assert property (p_ovr_sync) else $error("sync did not clear");

  property p_nr_timeout;
    clkEn && accessIn.accessReq && !accessIn.freeCycle && !accessSuppress
      [*1] ##0 timeoutHit |=> debugStatusLow[`DSF_NO_RESPONSE_FLAG_BIT];
  endproperty
  a_nr_timeout: assert property (p_nr_timeout) else $error("timeout flag");

  property p_nr_w1c;
    clkEn && debugStatusLow[`DSF_NO_RESPONSE_FLAG_BIT]
      && !(statusWrite && statusWrData[`DSF_NO_RESPONSE_FLAG_BIT])
      |=> debugStatusLow[`DSF_NO_RESPONSE_FLAG_BIT];
  endproperty
  a_nr_w1c: assert property (p_nr_w1c) else $error("no_response_flag cleared");

  property p_set_wins;
    clkEn && nrSet && nrClear |=> debugStatusLow[`DSF_NO_RESPONSE_FLAG_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat set");

  property p_subst;
    readDataValid && debugStatusLow[`DSF_NO_RESPONSE_FLAG_BIT] |-> readDataOut == `DSF_SUBST_BYTE;
  endproperty
  a_subst: assert property (p_subst) else $error("no substitute");

  property p_read_invalid_flag;
    clkEn && riSet && !status_next[`DSF_NO_RESPONSE_FLAG_BIT] |=> debugStatusLow[`DSF_READ_INVALID_FLAG_BIT]
      && readDataOut == $past(accessIn.readData);
  endproperty
  a_read_invalid_flag: assert property (p_read_invalid_flag) else $error("read invalid");

  property p_abort_wait;
    abortAccess && $past(clkEn) |-> !$past(accessIn.extWait);
  endproperty
  a_abort_wait: assert property (p_abort_wait) else $error("abort in wait");

  property p_wait_cmd;
    clkEn && modeIn.waitReturnPending && cmdIn.cmdStart |=> debugStatusLow[`DSF_NO_RESPONSE_FLAG_BIT];
  endproperty
  a_wait_cmd: assert property (p_wait_cmd) else $error("wait return");

  c_overrun: cover property (debugStatusLow[`DSF_OVERRUN_BIT] ##[1:20]
                             !debugStatusLow[`DSF_OVERRUN_BIT]);
  c_timeout: cover property (timeoutHit ##1 abortAccess);
  c_held:    cover property (abort_reg == DSF_AB_HOLD ##[1:20] abortAccess);
  c_read_invalid_flag:   cover property (riSet ##1 debugStatusLow[`DSF_READ_INVALID_FLAG_BIT]);

endmodule // dsf_status_flags

// ---- hdl/dsf_params.svh ----
`ifndef DSF_PARAMS_SVH
`define DSF_PARAMS_SVH

// Bit positions of the flags in the low debug status byte.
`define DSF_OVERRUN_BIT   3'd4
`define DSF_NO_RESPONSE_FLAG_BIT    3'd3
`define DSF_READ_INVALID_FLAG_BIT     3'd2

// Reset value of the low status byte and the substitute data byte.
`define DSF_STATUS_RESET  8'h00
`define DSF_SUBST_BYTE    8'hEE

// Core clock cycles an access may wait for a free bus cycle.
`define DSF_NO_RESPONSE_FLAG_CYCLES 512
`define DSF_TIMER_WIDTH   10

`endif

// ---- hdl/dsf_pkg.sv ----
package dsf_pkg;

  // Command events from the serial command decoder, one-cycle pulses except cmdBusy.
  typedef struct packed {
    logic cmdStart;
    logic cmdBusy;
    logic syncReq;
    logic dataRetrieveStart;
    logic enterDebugCmd;
    logic cpuRegCmd;
    logic singleStepCmd;
    logic memOrPcCmd;
  } dsf_cmd_s;

  // Levels describing handshake configuration and CPU power modes.
  typedef struct packed {
    logic ackEnable;
    logic ackPending;
    logic cycleBitA;
    logic stopMode;
    logic stopClockKeep;
    logic waitMode;
    logic enteringWait;
    logic waitReturnPending;
    logic bdcEnabled;
  } dsf_mode_s;

  // State of the internal access on the chip bus.
  typedef struct packed {
    logic       accessReq;
    logic       isWrite;
    logic       freeCycle;
    logic       abortable;
    logic       extWait;
    logic       readValid;
    logic       eccError;
    logic [7:0] readData;
  } dsf_access_s;

  typedef enum logic [0:0] {
    DSF_AB_IDLE = 1'b0,
    DSF_AB_HOLD = 1'b1
  } dsf_abort_e;

endpackage

// ---- hdl/dsf_timeout.sv ----
`timescale 1ns/100ps
`include "dsf_params.svh"

module dsf_timeout #(
  parameter int LIMIT = `DSF_NO_RESPONSE_FLAG_CYCLES,
  parameter int WIDTH = `DSF_TIMER_WIDTH
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic clkEn,
  // Wait condition and expiry
  input  wire logic waiting,
  output logic      expired
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic             expired_next;

  // A limit the counter cannot reach would never expire, so refuse it at elaboration.
  if (LIMIT < 2 || LIMIT >= (1 << WIDTH)) begin : g_bad_limit
    $error("dsf_timeout: LIMIT does not fit the counter");
  end

  // The counter restarts whenever a free cycle ends the wait, so only a
  // continuous wait of LIMIT cycles expires; expiry pulses for one cycle and repeats every LIMIT cycles while the wait lasts.
  always_comb begin
    count_next   = '0;
    expired_next = 1'b0;
    if (waiting) begin
      if (count_reg == WIDTH'(LIMIT - 1)) begin
        expired_next = 1'b1;
        count_next   = '0;
      end else begin
        count_next = count_reg + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
      expired   <= 1'b0;
    end else if (clkEn) begin
      count_reg <= count_next;
      expired   <= expired_next;
    end
  end

endmodule // dsf_timeout

// ---- dv/dsf_host_model.sv ----
`timescale 1ns/100ps

module dsf_host_model (
  // Clock
  input  wire logic       sys_clk,
  // Pin and host requests
  output logic            debugPin,
  output logic            syncReq,
  output logic            statusWrite,
  output logic [7:0]      statusWrData
);
  initial begin
    debugPin     = 1'b1;
    syncReq      = 1'b0;
    statusWrite  = 1'b0;
    statusWrData = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // The pin has a pull-up, so a released pin always returns high.
  task automatic pullLow(input int cycles);
    @(negedge sys_clk);
    debugPin = 1'b0;
    repeat (cycles) @(negedge sys_clk);
    debugPin = 1'b1;
  endtask

  // A long low pulse, reported by the decoder once the pin is back high.
  task automatic sendSync();
    pullLow(16);
    syncReq = 1'b1;
    @(negedge sys_clk);
    syncReq = 1'b0;
  endtask

  // Released data is inverted so that a stale value can never pass for a write.
  task automatic writeStatus(input logic [7:0] data);
    @(negedge sys_clk);
    statusWrite  = 1'b1;
    statusWrData = data;
    @(negedge sys_clk);
    statusWrite  = 1'b0;
    statusWrData = ~data;
  endtask
endmodule // dsf_host_model

// ---- dv/dsf_status_flags_tb.sv ----
`timescale 1ns/100ps

module dsf_status_flags_tb;
  import dsf_pkg::*;
  localparam int NC = 8;
  logic        sys_clk;
  logic        reset_n;
  logic        debugPin;
  logic        hostSync;
  logic        statusWrite;
  logic [7:0]  statusWrData;
  logic [7:0]  debugStatusLow;
  logic        accessSuppress;
  logic        abortAccess;
  logic        debugEnter;
  logic [7:0]  readDataOut;
  logic        readDataValid;
  dsf_cmd_s    cmd;
  dsf_cmd_s    cmdBus;
  dsf_mode_s   mode;
  dsf_access_s acc;
  logic [7:0]  rnd;
  logic [7:0]  expData[$];
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          sawAbort = 0;
  int          sawEnter = 0;
  int          modelStatus = 0;
  int          n;
  int          caseList[7] = '{0, 1, 2, 3, 3, 4, 5};

  dsf_host_model host_u (.sys_clk(sys_clk), .debugPin(debugPin), .syncReq(hostSync),
    .statusWrite(statusWrite), .statusWrData(statusWrData));
  dsf_status_flags #(.NO_RESPONSE_FLAG_CYCLES(NC)) dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
    .clkEn(1'b1), .debugPin(debugPin), .cmdIn(cmdBus), .modeIn(mode), .accessIn(acc),
    .statusWrite(statusWrite), .statusWrData(statusWrData), .debugStatusLow(debugStatusLow),
    .accessSuppress(accessSuppress), .abortAccess(abortAccess), .debugEnter(debugEnter),
    .readDataOut(readDataOut), .readDataValid(readDataValid));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always_comb begin
    cmdBus         = cmd;
    cmdBus.syncReq = cmd.syncReq | hostSync;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic tick(input int cnt = 1);
    repeat (cnt) @(negedge sys_clk);
  endtask

  task automatic checkStatus(input string msg);
    check(debugStatusLow, modelStatus[7:0], msg);
  endtask

  task automatic waitBit(input int b, input int lim, output int cnt);
    cnt = 0;
    while (debugStatusLow[b] !== 1'b1 && cnt < lim) begin
      tick();
      cnt++;
    end
  endtask

  // Bit 4 is deliberately left alone: only a SYNC may clear it.
  task automatic clearFlags(input logic [7:0] mask);
    host_u.writeStatus(mask);
    modelStatus &= ~int'(mask & 8'h0C);
    checkStatus("write clear");
  endtask

  task automatic readByte(input logic ecc);
    rnd = 8'($urandom());
    if (ecc) modelStatus |= 32'h04;
    expData.push_back(modelStatus[3] ? 8'hEE : rnd);
    acc.readValid = 1'b1;
    acc.eccError  = ecc;
    acc.readData  = rnd;
    tick();
    acc = '0;
    checkStatus("read status");
  endtask

  // Only the access causes may abort; the wait-mode causes leave the access alone.
  task automatic noRespCase(input int k);
    sawAbort = 0;
    case (k)
      0: acc.accessReq = 1'b1;
      1: {mode.ackEnable, mode.cycleBitA, acc.accessReq, acc.isWrite} = 4'hF;
      2: mode.stopMode = 1'b1;
      3: mode.waitMode = 1'b1;
      4: mode.waitReturnPending = 1'b1;
      default: {mode.bdcEnabled, mode.enteringWait} = 2'h3;
    endcase
    acc.freeCycle = 1'b1;
    acc.abortable = 1'b1;
    cmd.dataRetrieveStart = (k == 0);
    cmd.cmdStart = (k == 1 || k == 4);
    cmd.memOrPcCmd = (k == 2);
    cmd.cpuRegCmd = (k == 3);
    cmd.singleStepCmd = (k == 5);
    tick();
    {cmd, mode, acc} = '0;
    modelStatus |= 32'h08;
    checkStatus("no-response cause");
    clearFlags(8'h08);
    check(8'(sawAbort), (k < 3) ? 8'h01 : 8'h00, "abort on cause");
  endtask

  always @(negedge sys_clk) begin
    cycles++;
    if (abortAccess === 1'b1) sawAbort++;
    if (debugEnter === 1'b1) sawEnter++;
    if (readDataValid === 1'b1) begin
      check(readDataOut, (expData.size() > 0) ? expData.pop_front() : 8'h00, "data");
    end
    if (cycles > 5000) begin
      num_errors++;
      $display("Error at %0t: run did not finish in time", $time);
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    {cmd, mode, acc} = '0;
    void'($urandom(80));
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    checkStatus("reset value");
    check({accessSuppress, abortAccess, debugEnter, readDataValid, 4'h0}, 8'h00, "reset outs");
    $display("Test reset done");
    {cmd.cmdBusy, cmd.cmdStart} = 2'h3;
    tick();
    cmd = '0;
    modelStatus |= 32'h10;
    checkStatus("overrun");
    check({7'h00, accessSuppress}, 8'h01, "suppress");
    acc.accessReq = 1'b1;
    clearFlags(8'h1C);
    tick(3 * NC);
    checkStatus("no timeout while suppressed");
    acc = '0;
    host_u.sendSync();
    modelStatus &= ~32'h10;
    checkStatus("sync clear");
    {mode.ackEnable, mode.ackPending} = 2'h3;
    host_u.pullLow(2);
    waitBit(4, 8, n);
    modelStatus |= 32'h10;
    checkStatus("pin low in handshake");
    mode = '0;
    host_u.sendSync();
    modelStatus &= ~32'h10;
    checkStatus("sync clear again");
    $display("Test overrun done");
    {acc.accessReq, acc.abortable, acc.extWait} = 3'h7;
    sawAbort = 0;
    waitBit(3, 4 * NC, n);
    check(8'(n), 8'(NC + 1), "timeout length");
    modelStatus |= 32'h08;
    tick(4);
    check(8'(sawAbort), 8'h00, "abort held by wait");
    acc.extWait = 1'b0;
    tick(3);
    check(8'(sawAbort), 8'h01, "abort after wait");
    acc = '0;
    readByte(1'b0);
    clearFlags(8'h00);
    clearFlags(8'h08);
    readByte(1'b1);
    clearFlags(8'h04);
    $display("Test timeout and reads done");
    fork
      host_u.writeStatus(8'h08);
      begin
        tick();
        mode.stopMode = 1'b1;
        cmd.memOrPcCmd = 1'b1;
        tick();
        {cmd, mode} = '0;
      end
    join
    modelStatus |= 32'h08;
    checkStatus("set beats clear");
    clearFlags(8'h08);
    foreach (caseList[i]) noRespCase(caseList[i]);
    $display("Test no-response causes done");
    mode.waitMode = 1'b1;
    cmd.enterDebugCmd = 1'b1;
    sawEnter = 0;
    tick();
    cmd = '0;
    modelStatus |= 32'h08;
    checkStatus("enter debug in wait");
    tick(4);
    check(8'(sawEnter), 8'h00, "no entry in wait");
    mode.waitMode = 1'b0;
    tick(3);
    check(8'(sawEnter), 8'h01, "entry after wait");
    clearFlags(8'h08);
    sawEnter = 0;
    cmd.enterDebugCmd = 1'b1;
    tick();
    cmd = '0;
    tick();
    check(8'(sawEnter), 8'h01, "entry outside wait");
    checkStatus("no flag outside wait");
    $display("Test wait entry done");
    check(8'(expData.size()), 8'h00, "reads returned");
    print_verdict();
  end
endmodule // dsf_status_flags_tb
